/* hw/homing_pkg.sv */
// Constants, register map and carrier types of the homing sequencer.
// Assumes one core clock; settings reach the block over a plain register port.
package homing_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int SPEED_W = 26;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CONTROL_WORD_1 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_POS_CONTROL_WORD = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_POS_CONTROL_WORD_2 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_HOMING_CONFIG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CAM_SEARCH_SPEED = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_ZERO_MARK_SEARCH_SPEED = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_REF_POINT_APPROACH_SPEED = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_CAM_SEARCH_MAX_DISTANCE = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_ZERO_MARK_MAX_DISTANCE = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_REF_POINT_COORDINATE = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_REF_POINT_OFFSET = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_STATUS_WORD_1 = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_HOMING_STATUS = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_ADJUST_COMMAND = 8'h34;

    // Bit positions
    localparam int BIT_HOMING_START = 11;
    localparam int BIT_REFERENCED = 11;
    localparam int BIT_SET_REF_POINT = 1;
    localparam int BIT_REF_CAM = 2;
    localparam int BIT_DIRECTION_111 = 9;
    localparam int CFG_MODE_LO = 0;
    localparam int CFG_REV_CAM = 2;
    localparam int CFG_START_DIR = 3;
    localparam int CFG_FORMAT_LO = 4;
    localparam int CFG_ABS_ENCODER = 6;
    localparam int CMD_ABS_ADJUST = 0;

    // Homing modes
    localparam logic [1:0] MODE_REF_SIGNAL = 2'h0;
    localparam logic [1:0] MODE_CAM_ZERO_MARK = 2'h1;
    localparam logic [1:0] MODE_ZERO_MARK_ONLY = 2'h2;

    // Message format codes: 7 or 9 use digital inputs
    localparam logic [1:0] FMT_DIGITAL = 2'h0;
    localparam logic [1:0] FMT_110 = 2'h1;
    localparam logic [1:0] FMT_111 = 2'h2;

    // Factory values; speeds in units of 1000 length units per minute
    localparam logic [1:0] RST_MODE = MODE_CAM_ZERO_MARK;
    localparam logic RST_START_DIR = 1'b0;
    localparam logic [SPEED_W-1:0] RST_CAM_SEARCH_SPEED = 26'h0001388;
    localparam logic [SPEED_W-1:0] RST_ZERO_MARK_SPEED = 26'h000012C;
    localparam logic [SPEED_W-1:0] RST_APPROACH_SPEED = 26'h000012C;
    localparam logic [SPEED_W-1:0] SPEED_MAX = 26'h2625A00;
    localparam logic [SPEED_W-1:0] SPEED_MIN = 26'h0000001;
    localparam logic [31:0] RST_CAM_MAX_DISTANCE = 32'h7FFFFC17;
    localparam logic [31:0] RST_ZERO_MAX_DISTANCE = 32'h00004E20;
    localparam logic [31:0] DISTANCE_MAX = 32'h7FFFFC17;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_CAM_SEARCH = 7'b0000010,
        ST_CAM_STOP = 7'b0000100,
        ST_ZERO_SEARCH = 7'b0001000,
        ST_APPROACH = 7'b0010000,
        ST_DONE = 7'b0100000,
        ST_FAULT = 7'b1000000
    } homing_state_e;

    typedef struct packed {
        logic [15:0] control_word_1;
        logic [15:0] positioning_control_word;
        logic [15:0] positioning_control_word_2;
        logic [1:0] homing_mode_select;
        logic reversing_cam_enable;
        logic search_start_direction;
        logic [1:0] message_format;
        logic absolute_encoder;
        logic [SPEED_W-1:0] cam_search_speed;
        logic [SPEED_W-1:0] zero_mark_search_speed;
        logic [SPEED_W-1:0] ref_point_approach_speed;
        logic [31:0] cam_search_max_distance;
        logic [31:0] zero_mark_max_distance;
        logic signed [31:0] ref_point_coordinate;
        logic signed [31:0] ref_point_offset;
    } settings_s;

    // Command to the motion generator
    typedef struct packed {
        logic run;
        logic negative;
        logic [SPEED_W-1:0] speed;
    } motion_cmd_s;

    // Request to overwrite the actual position
    typedef struct packed {
        logic load;
        logic signed [31:0] value;
    } position_load_s;
endpackage

/* hw/servo_homing_sequencer.sv */
// Homing sequencer of a servo positioner: reference point set or searched.
// Assumes a motion generator on core_clk that follows motion_cmd and
// reports actual position and standstill; cam and zero-mark pins are async.
//
// The register addresses and the strobed register port were chosen for this implementation.

module servo_homing_sequencer
    import homing_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic cam_pin,
    input wire logic reversing_cam_pin,
    input wire logic zero_mark_pin,
    input wire logic signed [31:0] position_actual,
    input wire logic standstill,
    output motion_cmd_s motion_cmd,
    output position_load_s position_load,
    output logic referenced_flag,
    output logic homing_error
);

    typedef struct packed {
        settings_s cfg;
        homing_state_e state;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic cam_prev;
        logic rev_prev;
        logic zero_prev;
        logic search_negative;
        logic signed [31:0] search_origin;
        logic signed [31:0] target;
        logic referenced;
        logic error;
        logic adjusted;
        logic refused;
        motion_cmd_s cmd;
        position_load_s load;
        logic [DATA_W-1:0] rdata;
    } state_s;

    state_s r;
    state_s next_r;

    // Distance travelled, kept one bit wider so it cannot wrap
    function automatic logic [32:0] travel(input logic signed [31:0] a,
                                           input logic signed [31:0] b);
        logic signed [32:0] d;
        d = 33'(a) - 33'(b);
        travel = d[32] ? 33'(-d) : 33'(d);
    endfunction

    function automatic logic [SPEED_W-1:0] clamp_speed(input logic [31:0] v);
        logic [SPEED_W-1:0] s;
        s = v[SPEED_W-1:0];
        if (v > 32'(SPEED_MAX))
            s = SPEED_MAX;
        else if (v < 32'(SPEED_MIN))
            s = SPEED_MIN;
        clamp_speed = s;
    endfunction

    function automatic logic [31:0] clamp_distance(input logic [31:0] v);
        clamp_distance = (v > DISTANCE_MAX) ? DISTANCE_MAX : v;
    endfunction

    // Picks the cam bit from the word that the message format names
    function automatic logic pick_cam(input settings_s c, input int bit_pos,
                                      input logic pin);
        logic v;
        unique case (c.message_format)
            FMT_111: v = c.positioning_control_word_2[bit_pos];
            FMT_110: v = c.positioning_control_word[bit_pos];
            default: v = pin;
        endcase
        pick_cam = v;
    endfunction

    logic cam_level;
    logic cam_rise;
    logic rev_rise;
    logic zero_rise;
    logic start_bit;
    logic start_dir;
    logic mode_allowed;
    logic signed [31:0] approach_target;

    always_comb
    begin
        start_bit = r.cfg.control_word_1[BIT_HOMING_START];
        if (r.cfg.homing_mode_select == MODE_REF_SIGNAL)
            cam_level = pick_cam(r.cfg, BIT_SET_REF_POINT, r.sync2[0]);
        else
            cam_level = pick_cam(r.cfg, BIT_REF_CAM, r.sync2[0]);
        cam_rise = cam_level && !r.cam_prev;
        rev_rise = r.sync2[1] && !r.rev_prev;
        zero_rise = r.sync2[2] && !r.zero_prev;
        start_dir = r.cfg.search_start_direction;
        if (r.cfg.message_format == FMT_111)
            start_dir = r.cfg.positioning_control_word_2[BIT_DIRECTION_111];
        mode_allowed = (r.cfg.homing_mode_select == MODE_CAM_ZERO_MARK)
            || (r.cfg.homing_mode_select == MODE_ZERO_MARK_ONLY);
        if (r.cfg.absolute_encoder && r.adjusted)
            mode_allowed = 1'b0;
        approach_target = 32'(position_actual + r.cfg.ref_point_offset);
    end

    always_comb
    begin
        next_r = r;
        next_r.sync1 = {zero_mark_pin, reversing_cam_pin, cam_pin};
        next_r.sync2 = r.sync1;
        next_r.cam_prev = cam_level;
        next_r.rev_prev = r.sync2[1];
        next_r.zero_prev = r.sync2[2];
        next_r.load.load = 1'b0;
        next_r.rdata = '0;

        // Register writes
        if (reg_write)
        begin
            unique case (reg_addr)
                OFS_CONTROL_WORD_1:
                    next_r.cfg.control_word_1 = reg_wdata[15:0];
                OFS_POS_CONTROL_WORD:
                    next_r.cfg.positioning_control_word = reg_wdata[15:0];
                OFS_POS_CONTROL_WORD_2:
                    next_r.cfg.positioning_control_word_2 = reg_wdata[15:0];
                OFS_HOMING_CONFIG:
                begin
                    if (reg_wdata[CFG_MODE_LO+:2] != 2'h3)
                        next_r.cfg.homing_mode_select = reg_wdata[CFG_MODE_LO+:2];
                    next_r.cfg.reversing_cam_enable = reg_wdata[CFG_REV_CAM];
                    next_r.cfg.search_start_direction = reg_wdata[CFG_START_DIR];
                    next_r.cfg.message_format = reg_wdata[CFG_FORMAT_LO+:2];
                    next_r.cfg.absolute_encoder = reg_wdata[CFG_ABS_ENCODER];
                end
                OFS_CAM_SEARCH_SPEED:
                    next_r.cfg.cam_search_speed = clamp_speed(reg_wdata);
                OFS_ZERO_MARK_SEARCH_SPEED:
                    next_r.cfg.zero_mark_search_speed = clamp_speed(reg_wdata);
                OFS_REF_POINT_APPROACH_SPEED:
                    next_r.cfg.ref_point_approach_speed = clamp_speed(reg_wdata);
                OFS_CAM_SEARCH_MAX_DISTANCE:
                    next_r.cfg.cam_search_max_distance = clamp_distance(reg_wdata);
                OFS_ZERO_MARK_MAX_DISTANCE:
                    next_r.cfg.zero_mark_max_distance = clamp_distance(reg_wdata);
                OFS_REF_POINT_COORDINATE:
                    next_r.cfg.ref_point_coordinate = reg_wdata;
                OFS_REF_POINT_OFFSET:
                    next_r.cfg.ref_point_offset = reg_wdata;
                OFS_ADJUST_COMMAND:
                    if (reg_wdata[CMD_ABS_ADJUST] && r.cfg.absolute_encoder
                        && r.state == ST_IDLE)
                    begin
                        // Current position becomes zero
                        next_r.adjusted = 1'b1;
                        next_r.load.load = 1'b1;
                        next_r.load.value = '0;
                    end
                default:
                    next_r.cfg = r.cfg;
            endcase
        end

        // Register reads, data in the following cycle
        if (reg_read)
        begin
            unique case (reg_addr)
                OFS_CONTROL_WORD_1:
                    next_r.rdata = 32'(r.cfg.control_word_1);
                OFS_POS_CONTROL_WORD:
                    next_r.rdata = 32'(r.cfg.positioning_control_word);
                OFS_POS_CONTROL_WORD_2:
                    next_r.rdata = 32'(r.cfg.positioning_control_word_2);
                OFS_HOMING_CONFIG:
                    next_r.rdata = 32'({r.cfg.absolute_encoder, r.cfg.message_format,
                        r.cfg.search_start_direction, r.cfg.reversing_cam_enable,
                        r.cfg.homing_mode_select});
                OFS_CAM_SEARCH_SPEED:
                    next_r.rdata = 32'(r.cfg.cam_search_speed);
                OFS_ZERO_MARK_SEARCH_SPEED:
                    next_r.rdata = 32'(r.cfg.zero_mark_search_speed);
                OFS_REF_POINT_APPROACH_SPEED:
                    next_r.rdata = 32'(r.cfg.ref_point_approach_speed);
                OFS_CAM_SEARCH_MAX_DISTANCE:
                    next_r.rdata = r.cfg.cam_search_max_distance;
                OFS_ZERO_MARK_MAX_DISTANCE:
                    next_r.rdata = r.cfg.zero_mark_max_distance;
                OFS_REF_POINT_COORDINATE:
                    next_r.rdata = r.cfg.ref_point_coordinate;
                OFS_REF_POINT_OFFSET:
                    next_r.rdata = r.cfg.ref_point_offset;
                OFS_STATUS_WORD_1:
                    next_r.rdata = 32'(r.referenced) << BIT_REFERENCED;
                OFS_HOMING_STATUS:
                    next_r.rdata = 32'({r.refused, r.adjusted, r.error, r.state});
                default:
                    next_r.rdata = '0;
            endcase
        end

        // Sequencer
        unique case (r.state)
            ST_IDLE:
            begin
                next_r.cmd.run = 1'b0;
                if (r.cfg.homing_mode_select == MODE_REF_SIGNAL)
                begin
                    // Start bit held low while latching; standstill is not checked
                    if (cam_rise && !start_bit)
                    begin
                        next_r.load.load = 1'b1;
                        next_r.load.value = '0;
                        next_r.referenced = 1'b1;
                        next_r.error = 1'b0;
                    end
                end
                else if (start_bit)
                begin
                    next_r.refused = !mode_allowed;
                    if (mode_allowed)
                    begin
                        next_r.referenced = 1'b0;
                        next_r.error = 1'b0;
                        next_r.search_origin = position_actual;
                        next_r.cmd.run = 1'b1;
                        if (r.cfg.homing_mode_select == MODE_CAM_ZERO_MARK)
                        begin
                            next_r.search_negative = start_dir;
                            next_r.cmd.negative = start_dir;
                            next_r.cmd.speed = r.cfg.cam_search_speed;
                            next_r.state = ST_CAM_SEARCH;
                        end
                        else
                        begin
                            next_r.cmd.negative = start_dir;
                            next_r.cmd.speed = r.cfg.zero_mark_search_speed;
                            next_r.state = ST_ZERO_SEARCH;
                        end
                    end
                end
            end
            ST_CAM_SEARCH:
            begin
                if (cam_rise)
                begin
                    next_r.cmd.run = 1'b0;
                    next_r.state = ST_CAM_STOP;
                end
                else if (travel(position_actual, r.search_origin)
                         > 33'(r.cfg.cam_search_max_distance))
                begin
                    next_r.cmd.run = 1'b0;
                    next_r.error = 1'b1;
                    next_r.state = ST_FAULT;
                end
                else if (rev_rise && r.cfg.reversing_cam_enable)
                begin
                    next_r.search_negative = !r.search_negative;
                    next_r.cmd.negative = !r.search_negative;
                end
            end
            ST_CAM_STOP:
            begin
                if (standstill)
                begin
                    next_r.search_origin = position_actual;
                    next_r.cmd.run = 1'b1;
                    next_r.cmd.negative = !start_dir;
                    next_r.cmd.speed = r.cfg.zero_mark_search_speed;
                    next_r.state = ST_ZERO_SEARCH;
                end
            end
            ST_ZERO_SEARCH:
            begin
                // Cam falling edge is passed over; only the mark counts
                if (zero_rise)
                begin
                    next_r.target = approach_target;
                    next_r.cmd.negative = r.cfg.ref_point_offset < 0;
                    next_r.cmd.speed = r.cfg.ref_point_approach_speed;
                    next_r.cmd.run = r.cfg.ref_point_offset != 0;
                    next_r.state = ST_APPROACH;
                end
                else if (travel(position_actual, r.search_origin)
                         > 33'(r.cfg.zero_mark_max_distance))
                begin
                    next_r.cmd.run = 1'b0;
                    next_r.error = 1'b1;
                    next_r.state = ST_FAULT;
                end
            end
            ST_APPROACH:
            begin
                if (!r.cmd.run || (r.cmd.negative ? position_actual <= r.target
                                   : position_actual >= r.target))
                begin
                    next_r.cmd.run = 1'b0;
                    next_r.load.load = 1'b1;
                    next_r.load.value = r.cfg.ref_point_coordinate;
                    next_r.referenced = 1'b1;
                    next_r.state = ST_DONE;
                end
            end
            ST_DONE, ST_FAULT:
            begin
                next_r.cmd.run = 1'b0;
                if (!start_bit)
                    next_r.state = ST_IDLE;
            end
            default:
            begin
                next_r.cmd.run = 1'b0;
                next_r.state = ST_IDLE;
            end
        endcase

        // Stop on cleared start bit while a search is running
        if (!start_bit && (r.state == ST_CAM_SEARCH || r.state == ST_CAM_STOP
            || r.state == ST_ZERO_SEARCH || r.state == ST_APPROACH))
        begin
            next_r.cmd.run = 1'b0;
            next_r.state = ST_IDLE;
            next_r.load.load = 1'b0;
            next_r.referenced = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            r <= '0;
            r.state <= ST_IDLE;
            r.cfg.homing_mode_select <= RST_MODE;
            r.cfg.search_start_direction <= RST_START_DIR;
            r.cfg.cam_search_speed <= RST_CAM_SEARCH_SPEED;
            r.cfg.zero_mark_search_speed <= RST_ZERO_MARK_SPEED;
            r.cfg.ref_point_approach_speed <= RST_APPROACH_SPEED;
            r.cfg.cam_search_max_distance <= RST_CAM_MAX_DISTANCE;
            r.cfg.zero_mark_max_distance <= RST_ZERO_MAX_DISTANCE;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign motion_cmd = r.cmd;
    assign position_load = r.load;
    assign referenced_flag = r.referenced;
    assign homing_error = r.error;

endmodule

/* verification/homing_chk.sv */
// Port checker of the homing sequencer, bound to the design top.
// Assumes one core clock and the synchronous active-low reset.
module homing_chk
    import homing_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic cam_pin,
    input wire motion_cmd_s motion_cmd,
    input wire position_load_s position_load,
    input wire logic referenced_flag,
    input wire logic homing_error
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    rdata_quiet_a: assert property (!reg_read |=> reg_rdata == '0)
        else $error("read data not idle");
    status_flag_a: assert property ((reg_read && reg_addr == OFS_STATUS_WORD_1) ##1
        $stable(referenced_flag) |-> reg_rdata[BIT_REFERENCED] == referenced_flag)
        else $error("status word flag mismatch");
    err_no_flag_a: assert property (homing_error |-> !referenced_flag)
        else $error("flag set during fault");
    err_no_run_a: assert property (homing_error |-> !motion_cmd.run)
        else $error("motion during fault");
    stop_clear_a: assert property (reg_write && reg_addr == OFS_CONTROL_WORD_1
        && !reg_wdata[BIT_HOMING_START] |-> ##[1:3] !motion_cmd.run)
        else $error("motion not stopped on clear");
    cam_stop_a: assert property ($rose(cam_pin) && motion_cmd.run |-> ##[1:4] !motion_cmd.run)
        else $error("no stop on cam");
    speed_range_a: assert property ($rose(motion_cmd.run)
        |-> motion_cmd.speed inside {[SPEED_MIN:SPEED_MAX]})
        else $error("speed out of range");
    load_pulse_a: assert property (position_load.load |=> !position_load.load)
        else $error("load longer than one cycle");
    flag_load_a: assert property ($rose(referenced_flag)
        |-> position_load.load || $past(position_load.load))
        else $error("flag without position load");
    cover property ($rose(referenced_flag));
    cover property ($rose(homing_error));
    cover property ($fell(motion_cmd.run) ##[1:20] $rose(motion_cmd.run));
endmodule
bind servo_homing_sequencer homing_chk u_chk (.core_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .cam_pin, .motion_cmd, .position_load,
    .referenced_flag, .homing_error);

/* verification/homing_motion_model.sv */
// Motion generator model: integrates speed into position, reports standstill.
// Assumes speed is travel per clock; standstill comes three idle cycles late.
module homing_motion_model
    import homing_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire motion_cmd_s motion_cmd,
    input wire position_load_s position_load,
    output logic signed [31:0] position_actual,
    output logic standstill
);
    logic [1:0] idle_cycles;
    assign standstill = idle_cycles == 2'h3;
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            position_actual <= 32'sh00001000;
            idle_cycles <= 2'h0;
        end
        else
        begin
            if (position_load.load)
                position_actual <= position_load.value;
            else if (motion_cmd.run)
                position_actual <= motion_cmd.negative ? position_actual - 32'(motion_cmd.speed)
                    : position_actual + 32'(motion_cmd.speed);
            idle_cycles <= motion_cmd.run ? 2'h0 : idle_cycles + 2'(idle_cycles != 2'h3);
        end
    end
endmodule

/* verification/servo_homing_sequencer_tb.sv */
// Testbench of the homing sequencer: register tasks and homing scenarios.
// Assumes the motion model closes the loop from command to position.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
`define WAIT(c) begin #1; for (n = 0; n < 300 && !(c); n++) begin @(posedge core_clk); \
    #1; end if (!(c)) begin fail_count++; complete_run; end end
module servo_homing_sequencer_tb
    import homing_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, cam_pin = 0, zero_mark_pin = 0;
    logic rev_pin = 0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, v;
    logic signed [31:0] position_actual;
    logic standstill, referenced_flag, homing_error;
    motion_cmd_s motion_cmd;
    position_load_s position_load;
    int fail_count = 0, checks = 0, n;
    localparam logic [7:0] DA [9] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28,
        8'h3C};
    localparam logic [31:0] DE [9] = '{32'h1, 32'h1388, 32'h12C, 32'h12C, 32'h7FFFFC17,
        32'h4E20, 32'h0, 32'h0, 32'h0};
    servo_homing_sequencer DUT (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .cam_pin(cam_pin), .reversing_cam_pin(rev_pin),
        .zero_mark_pin(zero_mark_pin), .position_actual(position_actual),
        .standstill(standstill), .motion_cmd(motion_cmd), .position_load(position_load),
        .referenced_flag(referenced_flag), .homing_error(homing_error));
    homing_motion_model u_model (.core_clk(core_clk), .reset_n(reset_n),
        .motion_cmd(motion_cmd), .position_load(position_load),
        .position_actual(position_actual), .standstill(standstill));
    initial forever #5 core_clk = ~core_clk;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1;
        @(posedge core_clk);
        reg_write <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge core_clk);
        reg_read <= 0;
        #1 d = reg_rdata;
    endtask
    task automatic wrd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
        wr(a, d);
        rd(a, v);
        `CHK(v, e)
    endtask
    task complete_run;
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task t_defaults;
        for (int i = 0; i < 9; i++)
        begin
            rd(DA[i], v);
            `CHK(v, DE[i])
        end
        wrd(8'h18, 32'h0, 32'h1);
        wrd(8'h18, 32'h3FFFFFF, 32'h2625A00);
        wrd(8'h1C, 32'hFFFFFFFF, 32'h7FFFFC17);
    endtask
    task t_mode0;
        `CHK(referenced_flag, 1'b0)
        wr(8'h0C, 32'h10);
        wr(8'h04, 32'h2);
        `WAIT(referenced_flag)
        @(posedge core_clk);
        #1 `CHK(position_actual, 32'sh0)
        wr(8'h04, 32'h0);
    endtask
    task t_mode1;
        wr(8'h0C, 32'h1);
        wr(8'h24, 32'h64);
        wr(8'h00, 32'h800);
        `WAIT(motion_cmd.run)
        `CHK({motion_cmd.negative, motion_cmd.speed}, {1'b0, 26'h1388})
        @(posedge core_clk) cam_pin <= 1;
        `WAIT(!motion_cmd.run)
        `CHK(referenced_flag, 1'b0)
        `WAIT(motion_cmd.run)
        `CHK({motion_cmd.negative, motion_cmd.speed}, {1'b1, 26'h12C})
        @(posedge core_clk) cam_pin <= 0;
        @(posedge core_clk) zero_mark_pin <= 1;
        @(posedge core_clk) zero_mark_pin <= 0;
        `WAIT(referenced_flag)
        @(posedge core_clk);
        #1 `CHK(position_actual, 32'sh64)
        rd(OFS_STATUS_WORD_1, v);
        `CHK(v[11], 1'b1)
        wr(8'h00, 32'h0);
        repeat (3) @(posedge core_clk);
        #1 `CHK(referenced_flag, 1'b1)
    endtask
    task t_word2;
        wr(8'h0C, 32'h21);
        wr(8'h08, 32'h200);
        wr(8'h00, 32'h800);
        `WAIT(motion_cmd.run)
        `CHK(motion_cmd.negative, 1'b1)
        wr(8'h08, 32'h204);
        `WAIT(!motion_cmd.run)
        `WAIT(motion_cmd.run)
        `CHK({motion_cmd.negative, motion_cmd.speed}, {1'b0, 26'h12C})
        wr(8'h00, 32'h0);
        `WAIT(!motion_cmd.run)
        `CHK({referenced_flag, homing_error}, 2'b00)
        wr(8'h08, 32'h0);
    endtask
    task t_reverse;
        wr(8'h0C, 32'h5);
        wr(8'h00, 32'h800);
        `WAIT(motion_cmd.run)
        @(posedge core_clk) rev_pin <= 1;
        `WAIT(motion_cmd.negative)
        `CHK({motion_cmd.run, motion_cmd.speed}, {1'b1, 26'h1388})
        @(posedge core_clk) rev_pin <= 0;
        wr(8'h00, 32'h0);
        `WAIT(!motion_cmd.run)
    endtask
    task t_mode2;
        wr(8'h0C, 32'h2);
        wr(8'h00, 32'h800);
        `WAIT(motion_cmd.run)
        `CHK({motion_cmd.negative, motion_cmd.speed}, {1'b0, 26'h12C})
        @(posedge core_clk) zero_mark_pin <= 1;
        @(posedge core_clk) zero_mark_pin <= 0;
        `WAIT(referenced_flag)
        @(posedge core_clk);
        #1 `CHK(position_actual, 32'sh64)
        wr(8'h00, 32'h0);
    endtask
    task t_limit;
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h800);
        `WAIT(motion_cmd.run)
        @(posedge core_clk) cam_pin <= 1;
        `WAIT(!motion_cmd.run)
        `WAIT(motion_cmd.run)
        `WAIT(homing_error)
        `CHK({referenced_flag, motion_cmd.run}, 2'b00)
        @(posedge core_clk) cam_pin <= 0;
        wr(8'h00, 32'h0);
    endtask
    task t_refused;
        wr(8'h0C, 32'h42);
        wr(8'h34, 32'h1);
        wr(8'h00, 32'h800);
        repeat (5) @(posedge core_clk);
        rd(OFS_HOMING_STATUS, v);
        `CHK({v[9], motion_cmd.run}, 2'b10)
        wr(8'h00, 32'h0);
    endtask
    initial
    begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1;
        t_defaults;
        t_mode0;
        t_mode1;
        t_word2;
        t_reverse;
        t_mode2;
        t_limit;
        t_refused;
        complete_run;
    end
endmodule
